// ### hdl/cxb_defs.svh
// Purpose: Constants of the coax to system bus bridge
// Assumes: Included by the package, cxb_top and the bench
// Notes:   Offsets, field positions and timing counts
`ifndef CXB_DEFS_SVH
`define CXB_DEFS_SVH
// =====================================================================
// Timing
`define CXB_CLK_MHZ        200
`define CXB_LINK_X100BPS   23587
`define CXB_BIT_CYC        ((`CXB_CLK_MHZ * 10000 + `CXB_LINK_X100BPS - 1) / `CXB_LINK_X100BPS)
// =====================================================================
// Frame layout, MSB first on the wire
`define CXB_FRM_BITS       12
`define CXB_FRM_START      11
`define CXB_FRM_CMD        10
`define CXB_FRM_DATA_HI    9
`define CXB_FRM_DATA_LO    2
`define CXB_FRM_PAR        1
// =====================================================================
// Command opcodes carried in a command frame
`define CXB_OP_POLL        8'h01
`define CXB_OP_WRITE       8'h02
`define CXB_OP_READ        8'h03
`define CXB_OP_ADDR_LO     8'h04
`define CXB_OP_ADDR_HI     8'h05
// =====================================================================
// Payload header and reset values
`define CXB_HDR_BYTES      14'h0004
`define CXB_SPACE_IO       8'h01
`define CXB_MSG_NOTIFY     8'h01
`define CXB_MSG_RST        8'h00
`endif

// ### hdl/cxb_pkg.sv
// Purpose: Types of the coax to system bus bridge
// Assumes: cxb_defs.svh on the include path
// Notes:   State records of both modules
`include "cxb_defs.svh"
package cxb_pkg;
   typedef enum logic [2:0] {FE_IDLE, FE_WRITE, FE_ADDR_LO, FE_ADDR_HI} cxb_fe_mode_t;
   typedef enum logic [2:0] {BE_IDLE, BE_FETCH, BE_WAIT, BE_ARB, BE_CYC, BE_DONE} cxb_be_t;

   typedef struct packed {
      logic [6:0]   div;
      logic [11:0]  rx_sh;
      logic [3:0]   rx_cnt;
      logic         rx_busy;
      logic [7:0]   rx_byte;
      logic         rx_cmd;
      logic         rx_par;
      logic         rx_valid;
      logic [11:0]  tx_sh;
      logic [3:0]   tx_cnt;
      logic         tx_busy;
      cxb_fe_mode_t mode;
      logic [13:0]  addr;
      logic [13:0]  wr_base;
      logic [13:0]  wr_len;
      logic         wr_pend;
      logic [7:0]   wdata;
      logic         rd_pend;
      logic         rd_wait;
      logic         attn;
      logic [7:0]   msg_fe;
      logic [7:0]   msg_be;
      cxb_be_t      be;
      logic [13:0]  be_ptr;
      logic [13:0]  be_idx;
      logic [13:0]  be_len;
      logic [7:0]   be_space;
      logic [23:0]  be_addr;
      logic [15:0]  be_word;
      logic         be_have;
      logic         be_wide;
      logic         intr;
   } cxb_top_st_t;

   typedef struct packed {
      logic       turn;
      logic       fe_rv;
      logic       be_rv;
      logic [7:0] rdata;
   } cxb_buf_st_t;
endpackage

// ### hdl/cxb_buf_if.sv
// Purpose: Two request ports of the shared buffer
// Assumes: One clock domain
// Notes:   Grants are combinational, read data one cycle later
`timescale 1ns/1ps
interface cxb_buf_if;
   logic        fe_req, fe_we, fe_gnt, fe_rv;
   logic [13:0] fe_addr;
   logic [7:0]  fe_wdata;
   logic        be_req, be_gnt, be_rv;
   logic [13:0] be_addr;
   logic [7:0]  rdata;
   modport mem  (input fe_req, fe_we, fe_addr, fe_wdata, be_req, be_addr,
                 output fe_gnt, fe_rv, be_gnt, be_rv, rdata);
   modport user (output fe_req, fe_we, fe_addr, fe_wdata, be_req, be_addr,
                 input fe_gnt, fe_rv, be_gnt, be_rv, rdata);
endinterface

// ### hdl/cxb_sbuf.sv
// Purpose: Shared buffer with two arbitrated ports
// Assumes: Requests hold until granted
// Notes:   Alternating priority on collision
`timescale 1ns/1ps
module cxb_sbuf #(
   parameter int DEPTH = 16384
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Buffer ports
   cxb_buf_if.mem   bp
);
   cxb_pkg::cxb_buf_st_t st, next_st;
   logic [7:0] mem [DEPTH];

   // One grant per cycle, turn flips on a collision
   assign bp.fe_gnt = bp.fe_req && (!bp.be_req || !st.turn);
   assign bp.be_gnt = bp.be_req && !bp.fe_gnt;
   assign bp.fe_rv  = st.fe_rv;
   assign bp.be_rv  = st.be_rv;
   assign bp.rdata  = st.rdata;

   // Next state
   always_comb begin
      next_st       = st;
      next_st.fe_rv = bp.fe_gnt && !bp.fe_we;
      next_st.be_rv = bp.be_gnt;
      if (bp.fe_req && bp.be_req) begin
         next_st.turn = !st.turn;
      end
      if (bp.fe_gnt) begin
         next_st.rdata = mem[bp.fe_addr];
      end else if (bp.be_gnt) begin
         next_st.rdata = mem[bp.be_addr];
      end
   end

   // Storage, written by the front end only
   always_ff @(posedge clk) begin
      if (bp.fe_gnt && bp.fe_we) begin
         mem[bp.fe_addr] <= bp.fe_wdata;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   a_single_grant: assert property (@(posedge clk) disable iff (rst)
      !(bp.fe_gnt && bp.be_gnt)) else $error("both buffer ports granted");
   a_read_returns: assert property (@(posedge clk) disable iff (rst)
      bp.be_gnt |=> bp.be_rv && !bp.fe_rv) else $error("buffer read not answered");
   c_collision: cover property (@(posedge clk) bp.fe_req && bp.be_req);
endmodule

// ### hdl/cxb_top.sv
// Purpose: Bridge between a coax display link and a multimaster system bus
// Assumes: Pins synchronous to clk, host waits for each reply frame
// Notes:   Payload header is space byte then 24-bit address, high first
`timescale 1ns/1ps
`include "cxb_defs.svh"
module cxb_top #(
   parameter int BIT_CYC = `CXB_BIT_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Coax link
   input  wire logic        coax_rx,
   output logic             coax_tx,
   output logic             coax_tx_oe,
   // Received frame view
   output logic [7:0]       rx_byte,
   output logic             rx_cmd,
   output logic             rx_par,
   output logic             rx_valid,
   // System bus
   output logic             sb_req,
   input  wire logic        sb_grant,
   output logic [23:0]      sb_addr,
   output logic [15:0]      sb_dout,
   output logic             sb_dout_oe,
   output logic             sb_mwr,
   output logic             sb_iowr,
   output logic             sb_wide,
   input  wire logic        sb_ack,
   input  wire logic        sb_attn_req,
   input  wire logic        sb_intr_ack,
   output logic             sb_intr
);
   cxb_pkg::cxb_top_st_t st, next_st;
   cxb_buf_if bp ();
   logic tick;
   logic [7:0] fb;

   cxb_sbuf u_sbuf (
      .clk (clk),
      .rst (rst),
      .bp  (bp.mem)
   );

   // Bit-rate enable and buffer requests
   assign tick        = (st.div == 7'(BIT_CYC - 1));
   assign bp.fe_req   = st.wr_pend || (st.rd_pend && !st.rd_wait);
   assign bp.fe_we    = st.wr_pend;
   assign bp.fe_addr  = st.addr;
   assign bp.fe_wdata = st.wdata;
   assign bp.be_req   = (st.be == cxb_pkg::BE_FETCH);
   assign bp.be_addr  = st.be_ptr;
   assign fb          = st.rx_sh[`CXB_FRM_DATA_HI-1:`CXB_FRM_DATA_LO-1];

   // Outputs
   assign coax_tx    = st.tx_sh[`CXB_FRM_START];
   assign coax_tx_oe = st.tx_busy;
   assign rx_byte    = st.rx_byte;
   assign rx_cmd     = st.rx_cmd;
   assign rx_par     = st.rx_par;
   assign rx_valid   = st.rx_valid;
   assign sb_req     = (st.be == cxb_pkg::BE_ARB) || (st.be == cxb_pkg::BE_CYC);
   assign sb_addr    = (st.be_space == `CXB_SPACE_IO) ? {8'h00, st.be_addr[15:0]}
                                                      : st.be_addr;
   assign sb_dout    = st.be_word;
   assign sb_dout_oe = (st.be == cxb_pkg::BE_CYC);
   assign sb_mwr     = sb_dout_oe && (st.be_space != `CXB_SPACE_IO);
   assign sb_iowr    = sb_dout_oe && (st.be_space == `CXB_SPACE_IO);
   assign sb_wide    = st.be_wide;
   assign sb_intr    = st.intr;

   // Next state
   always_comb begin
      next_st          = st;
      next_st.rx_valid = 1'b0;
      next_st.div      = tick ? 7'h00 : st.div + 7'h01;
      // Receiver: a one bit opens a frame
      if (tick) begin
         next_st.rx_sh = {st.rx_sh[10:0], coax_rx};
         if (!st.rx_busy && coax_rx) begin
            next_st.rx_busy = 1'b1;
            next_st.rx_cnt  = 4'h1;
         end else if (st.rx_busy) begin
            next_st.rx_cnt = st.rx_cnt + 4'h1;
            if (st.rx_cnt == 4'(`CXB_FRM_BITS - 1)) begin
               next_st.rx_busy  = 1'b0;
               next_st.rx_valid = 1'b1;
               next_st.rx_byte  = fb;
               next_st.rx_cmd   = st.rx_sh[`CXB_FRM_CMD-1];
               next_st.rx_par   = st.rx_sh[`CXB_FRM_PAR-1];
            end
         end
      end
      // Transmitter shifts one bit per tick
      if (tick && st.tx_busy) begin
         next_st.tx_sh  = {st.tx_sh[10:0], 1'b0};
         next_st.tx_cnt = st.tx_cnt + 4'h1;
         if (st.tx_cnt == 4'(`CXB_FRM_BITS - 1)) begin
            next_st.tx_busy = 1'b0;
         end
      end
      // Attention from a system bus agent, set wins over the poll clear
      if (st.rx_valid && st.rx_cmd && st.rx_byte == `CXB_OP_POLL && !st.tx_busy) begin
         next_st.attn    = 1'b0;
         next_st.tx_busy = 1'b1;
         next_st.tx_cnt  = 4'h0;
         next_st.div     = 7'h00; // start bit gets a full cell
         next_st.tx_sh   = {1'b1, 1'b0, st.attn, (st.be != cxb_pkg::BE_IDLE),
                            st.msg_be[5:0],
                            ^{st.attn, (st.be != cxb_pkg::BE_IDLE), st.msg_be[5:0]},
                            1'b0};
      end
      if (sb_attn_req) begin
         next_st.attn = 1'b1;
      end
      // Host commands and data frames
      if (st.rx_valid && st.rx_cmd) begin
         next_st.mode = cxb_pkg::FE_IDLE;
         if (st.mode == cxb_pkg::FE_WRITE && st.wr_len != 14'h0000) begin
            next_st.msg_fe = `CXB_MSG_NOTIFY;
         end
         case (st.rx_byte)
            `CXB_OP_WRITE: begin
               next_st.mode    = cxb_pkg::FE_WRITE;
               next_st.wr_base = st.addr;
               next_st.wr_len  = 14'h0000;
            end
            `CXB_OP_READ: begin
               next_st.rd_pend = 1'b1;
            end
            `CXB_OP_ADDR_LO: begin
               next_st.mode = cxb_pkg::FE_ADDR_LO;
            end
            `CXB_OP_ADDR_HI: begin
               next_st.mode = cxb_pkg::FE_ADDR_HI;
            end
            default: begin
            end
         endcase
      end else if (st.rx_valid) begin
         case (st.mode)
            cxb_pkg::FE_WRITE: begin
               next_st.wr_pend = 1'b1;
               next_st.wdata   = st.rx_byte;
            end
            cxb_pkg::FE_ADDR_LO: begin
               next_st.addr[7:0] = st.rx_byte;
            end
            cxb_pkg::FE_ADDR_HI: begin
               next_st.addr[13:8] = st.rx_byte[5:0];
            end
            default: begin
            end
         endcase
      end
      // Front-end buffer accesses
      if (bp.fe_gnt) begin
         next_st.addr = st.addr + 14'h0001;
         if (st.wr_pend) begin
            next_st.wr_pend = 1'b0;
            next_st.wr_len  = st.wr_len + 14'h0001;
         end else begin
            next_st.rd_wait = 1'b1;
         end
      end
      if (bp.fe_rv && !st.tx_busy) begin
         next_st.rd_pend = 1'b0;
         next_st.rd_wait = 1'b0;
         next_st.tx_busy = 1'b1;
         next_st.tx_cnt  = 4'h0;
         next_st.div     = 7'h00; // start bit gets a full cell
         next_st.tx_sh   = {1'b1, 1'b0, bp.rdata, ^bp.rdata, 1'b0};
      end
      // Back end
      case (st.be)
         cxb_pkg::BE_IDLE: begin
            if (st.msg_fe != `CXB_MSG_RST) begin
               next_st.be      = cxb_pkg::BE_FETCH;
               next_st.be_ptr  = st.wr_base;
               next_st.be_len  = st.wr_len;
               next_st.be_idx  = 14'h0000;
               next_st.be_have = 1'b0;
               next_st.msg_fe  = `CXB_MSG_RST;
            end
         end
         cxb_pkg::BE_FETCH: begin
            if (bp.be_gnt) begin
               next_st.be     = cxb_pkg::BE_WAIT;
               next_st.be_ptr = st.be_ptr + 14'h0001;
               next_st.be_idx = st.be_idx + 14'h0001;
            end
         end
         cxb_pkg::BE_WAIT: begin
            if (bp.be_rv) begin
               next_st.be = cxb_pkg::BE_FETCH;
               if (st.be_idx == 14'h0001) begin
                  next_st.be_space = bp.rdata;
               end else if (st.be_idx <= `CXB_HDR_BYTES) begin
                  next_st.be_addr = {st.be_addr[15:0], bp.rdata};
               end else if (!st.be_have) begin
                  next_st.be_word = {8'h00, bp.rdata};
                  next_st.be_have = 1'b1;
                  next_st.be_wide = 1'b0;
                  if (st.be_idx == st.be_len) begin
                     next_st.be = cxb_pkg::BE_ARB;
                  end
               end else begin
                  next_st.be_word[15:8] = bp.rdata;
                  next_st.be_wide       = 1'b1;
                  next_st.be            = cxb_pkg::BE_ARB;
               end
               if (st.be_idx >= st.be_len && st.be_idx <= `CXB_HDR_BYTES) begin
                  next_st.be = cxb_pkg::BE_DONE;
               end
            end
         end
         cxb_pkg::BE_ARB: begin
            if (sb_grant) begin
               next_st.be = cxb_pkg::BE_CYC;
            end
         end
         cxb_pkg::BE_CYC: begin
            if (sb_ack) begin
               next_st.be_have = 1'b0;
               next_st.be_addr = st.be_addr + (st.be_wide ? 24'h000002 : 24'h000001);
               next_st.be      = (st.be_idx == st.be_len) ? cxb_pkg::BE_DONE
                                                          : cxb_pkg::BE_FETCH;
            end
         end
         default: begin
            next_st.be     = cxb_pkg::BE_IDLE;
            next_st.intr   = 1'b1;
            next_st.msg_be = st.msg_be + 8'h01;
         end
      endcase
      if (sb_intr_ack && st.be != cxb_pkg::BE_DONE) begin
         next_st.intr = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Checks
   a_bit_spacing: assert property (@(posedge clk) disable iff (rst)
      tick |=> !tick) else $error("bit tick too frequent");
   a_frame_start: assert property (@(posedge clk) disable iff (rst)
      $rose(coax_tx_oe) |-> coax_tx) else $error("frame lacks start bit");
   a_frame_len: assert property (@(posedge clk) disable iff (rst)
      st.tx_busy && tick && st.tx_cnt == 4'hb |=> !coax_tx_oe) else $error("frame length");
   a_rx_pulse: assert property (@(posedge clk) disable iff (rst)
      rx_valid |=> !rx_valid) else $error("receive strobe too long");
   a_attn_set: assert property (@(posedge clk) disable iff (rst)
      sb_attn_req |=> st.attn) else $error("attention lost");
   a_bus_owned: assert property (@(posedge clk) disable iff (rst)
      sb_dout_oe |-> sb_req && $past(sb_grant)) else $error("bus driven without grant");
   a_done_intr: assert property (@(posedge clk) disable iff (rst)
      st.be == cxb_pkg::BE_DONE |=> sb_intr) else $error("no completion interrupt");
   a_notify_be: assert property (@(posedge clk) disable iff (rst)
      st.msg_fe != 8'h00 && st.be == cxb_pkg::BE_IDLE |=> st.be == cxb_pkg::BE_FETCH)
      else $error("back end not started");
   c_wide_xfer: cover property (@(posedge clk) sb_mwr && sb_wide);
   c_io_xfer: cover property (@(posedge clk) sb_iowr);
   c_poll_reply: cover property (@(posedge clk) $rose(coax_tx_oe) && st.attn);
endmodule

// ### dv/cxb_host_model.sv
// Purpose: Coax host model that sends frames and captures reply frames
// Assumes: BIT_CYC clocks per bit, line idles low between frames
// Notes:   Replies are sampled mid-bit on the falling clock edge
`timescale 1ns/1ps
module cxb_host_model #(
   parameter int BIT_CYC = 4
) (
   // Clock
   input  wire logic clk,
   // Coax link
   output logic      coax_rx,
   input  wire logic coax_tx,
   input  wire logic coax_tx_oe
);
   logic [11:0] rep_frame = 12'h000;
   logic [11:0] rx_sh     = 12'h000;
   logic        oe_d      = 1'b0;
   int          rep_cnt   = 0;
   int          oe_run    = 0;

   // ==========================================================
   // Sender: one bit per BIT_CYC clocks, MSB first, then idle low
   initial coax_rx = 1'b0;
   task automatic send_frame(input logic cmd, input logic [7:0] d);
      logic [11:0] f;
      f = {1'b1, cmd, d, ^d, 1'b0};
      for (int i = 11; i >= 0; i--) begin
         coax_rx <= f[i];
         repeat (BIT_CYC) @(posedge clk);
      end
      coax_rx <= 1'b0;
      repeat (2 * BIT_CYC) @(posedge clk);
   endtask

   // ==========================================================
   // Host waits for the reply before its next command
   task automatic wait_reply(output logic ok);
      int n;
      n = rep_cnt;
      ok = 1'b0;
      for (int i = 0; i < 100 * BIT_CYC; i++) begin
         @(posedge clk);
         if (rep_cnt != n) begin
            ok = 1'b1;
            break;
         end
      end
   endtask

   // ==========================================================
   // Receiver: counts enable length, samples each bit mid-cell
   always @(negedge clk) begin
      if (coax_tx_oe === 1'b1) begin
         if (!oe_d) begin
            oe_run = 0;
         end
         if (oe_run % BIT_CYC == BIT_CYC / 2) begin
            rx_sh = {rx_sh[10:0], coax_tx};
         end
         oe_run++;
      end else if (oe_d) begin
         rep_frame = rx_sh;
         rep_cnt++;
      end
      oe_d = (coax_tx_oe === 1'b1);
   end
endmodule

// ### dv/coax_host_to_system_bus_bridge_tb.sv
// Purpose: Self-checking bench of the coax to system bus bridge
// Assumes: Host model on the coax, bench answers the system bus
// Notes:   BIT_CYC shortened to 4 clocks per bit
`timescale 1ns/1ps
`include "cxb_defs.svh"
module coax_host_to_system_bus_bridge_tb;
   localparam int BC = 4;
   logic        clk         = 1'b0;
   logic        rst         = 1'b1;
   logic        coax_rx;
   logic        coax_tx;
   logic        coax_tx_oe;
   logic [7:0]  rx_byte;
   logic        rx_cmd;
   logic        rx_par;
   logic        rx_valid;
   logic        sb_req;
   logic        sb_grant    = 1'b0;
   logic [23:0] sb_addr;
   logic [15:0] sb_dout;
   logic        sb_dout_oe;
   logic        sb_mwr;
   logic        sb_iowr;
   logic        sb_wide;
   logic        sb_ack      = 1'b0;
   logic        sb_attn_req = 1'b0;
   logic        sb_intr_ack = 1'b0;
   logic        sb_intr;
   logic [41:0] bus_q[$];
   logic [9:0]  vlast;
   int          vcnt        = 0;
   int          wcnt        = 0;
   int          error_cnt   = 0;
   int          cmp_count   = 0;

   cxb_top #(.BIT_CYC(BC)) uut (.clk(clk), .rst(rst), .coax_rx(coax_rx), .coax_tx(coax_tx),
      .coax_tx_oe(coax_tx_oe), .rx_byte(rx_byte), .rx_cmd(rx_cmd), .rx_par(rx_par),
      .rx_valid(rx_valid), .sb_req(sb_req), .sb_grant(sb_grant), .sb_addr(sb_addr),
      .sb_dout(sb_dout), .sb_dout_oe(sb_dout_oe), .sb_mwr(sb_mwr), .sb_iowr(sb_iowr),
      .sb_wide(sb_wide), .sb_ack(sb_ack), .sb_attn_req(sb_attn_req),
      .sb_intr_ack(sb_intr_ack), .sb_intr(sb_intr));
   cxb_host_model #(.BIT_CYC(BC)) host (.clk(clk), .coax_rx(coax_rx), .coax_tx(coax_tx),
      .coax_tx_oe(coax_tx_oe));

   // ==========================================================
   // Clock and watchdog
   initial forever #2.5 clk = ~clk;
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      stop_test();
   end

   // ==========================================================
   // Bus answer: grant follows request, ack three cycles into a strobe
   always @(posedge clk) begin
      sb_grant <= sb_req;
      if ((sb_mwr | sb_iowr) === 1'b1 && !sb_ack) begin
         if (wcnt == 2) begin
            sb_ack <= 1'b1;
            wcnt <= 0;
            bus_q.push_back({sb_iowr, sb_wide, sb_addr, sb_dout});
         end else begin
            wcnt <= wcnt + 1;
         end
      end else if (sb_ack) begin
         sb_ack <= 1'b0;
      end
   end

   // Frame view monitor
   always @(negedge clk) begin
      if (rx_valid === 1'b1) begin
         vcnt++;
         vlast = {rx_cmd, rx_par, rx_byte};
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [41:0] seen, input logic [41:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic poll(output logic [7:0] st);
      logic ok;
      host.send_frame(1'b1, `CXB_OP_POLL);
      host.wait_reply(ok);
      check(ok, 1'b1);
      check({host.rep_frame[11], host.rep_frame[1:0]}, {1'b1, ^host.rep_frame[9:2], 1'b0});
      st = host.rep_frame[9:2];
   endtask

   task automatic set_addr(input logic [7:0] a);
      host.send_frame(1'b1, `CXB_OP_ADDR_LO);
      host.send_frame(1'b0, a);
      host.send_frame(1'b1, `CXB_OP_ADDR_HI);
      host.send_frame(1'b0, 8'h00);
   endtask

   task automatic run_job(input logic [7:0] base, input logic [7:0] pl[$], input int n);
      logic [7:0] st;
      bus_q.delete();
      set_addr(base);
      host.send_frame(1'b1, `CXB_OP_WRITE);
      foreach (pl[i]) host.send_frame(1'b0, pl[i]);
      poll(st);
      for (int i = 0; i < 2000 && !(bus_q.size() >= n && sb_intr === 1'b1); i++) @(posedge clk);
      check(bus_q.size(), n);
      check(sb_intr, 1'b1);
      sb_intr_ack <= 1'b1;
      @(posedge clk);
      sb_intr_ack <= 1'b0;
      repeat (2) @(posedge clk);
      check(sb_intr, 1'b0);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      check({coax_tx, coax_tx_oe, sb_req, sb_mwr, sb_iowr, sb_dout_oe, sb_intr}, 7'h00);
      $display("t_reset done");
   endtask

   task automatic t_rx_view();
      logic [7:0] st;
      int n;
      n = vcnt;
      host.send_frame(1'b0, 8'ha7);
      check(vcnt - n, 1);
      check(vlast, {1'b0, 1'b1, 8'ha7});
      poll(st);
      check(vlast, {1'b1, ^`CXB_OP_POLL, `CXB_OP_POLL});
      check(st[7], 1'b0);
      $display("t_rx_view done");
   endtask

   task automatic t_mem_job();
      logic ok;
      logic [11:0] f;
      run_job(8'h20, '{8'h00, 8'h12, 8'h34, 8'h56, 8'h11, 8'h22, 8'h33}, 2);
      check(bus_q[0], {1'b0, 1'b1, 24'h123456, 16'h2211});
      check({bus_q[1][41:16], bus_q[1][7:0]}, {2'b00, 24'h123458, 8'h33});
      set_addr(8'h24);
      host.send_frame(1'b1, `CXB_OP_READ);
      host.wait_reply(ok);
      check(ok, 1'b1);
      f = host.rep_frame;
      check(f[9:2], 8'h11);
      check({f[11], f[1:0]}, {1'b1, ^f[9:2], 1'b0});
      check(host.oe_run, 12 * BC);
      $display("t_mem_job done");
   endtask

   task automatic t_io_job();
      run_job(8'h40, '{`CXB_SPACE_IO, 8'h00, 8'hab, 8'hcd, 8'h77}, 1);
      check({bus_q[0][41:16], bus_q[0][7:0]}, {2'b10, 24'h00abcd, 8'h77});
      $display("t_io_job done");
   endtask

   task automatic t_attn();
      logic [7:0] st;
      sb_attn_req <= 1'b1;
      @(posedge clk);
      sb_attn_req <= 1'b0;
      poll(st);
      check(st[7], 1'b1);
      poll(st);
      check(st[7], 1'b0);
      $display("t_attn done");
   endtask

   // ==========================================================
   // Verdict and end of run
   task automatic stop_test();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      t_reset();
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_rx_view();
      t_mem_job();
      t_io_job();
      t_attn();
      stop_test();
   end
endmodule
